// >>> osv_dev.sv
// output limit supervisor, device end of the link
`timescale 1ns/1ps
module osv_dev (
  input  wire logic        CLK_SYS,        // system clock
  input  wire logic        RESET,          // synchronous, active high
  osv_link_if.dev          LINK,           // serial command link
  input  wire logic        RUN,            // channel run pin
  input  wire logic        OV_TRIP,        // overvoltage comparator pin
  input  wire logic        FAULT_STOP,     // other fault requesting shutdown
  input  wire logic        READING_STROBE, // one converter reading, same clock
  input  wire logic [15:0] OUT_READING,    // output reading
  input  wire logic [15:0] PEAK_READING,   // peak output reading
  output logic             HIGH_SIDE_GATE, // high side gate enable
  output logic             LOW_SIDE_GATE,  // low side gate enable
  output logic             SWITCHING,      // channel switching
  output logic             RAMPING,        // in ramp up or ramp down
  output logic [15:0]      TARGET,         // regulation target
  output logic             ALARM_N,        // shared alarm pin, low active
  output logic             ALERT_N         // alert, low active
);
  import osv_pkg::*;

  typedef struct packed {
    osv_dstate_t            st;
    logic [NREG-1:0][15:0]  regs;
    logic [7:0]             sv;
    logic                   cml;
    logic [6:0]             busy;
    logic [7:0]             tmr;
    logic [11:0]            toff;
    logic                   toff_arm;
    logic                   absent;
    logic [1:0]             below;
    logic                   ov_hold;
    logic [15:0]            target;
    logic [5:0]             s1;
    logic [5:0]             s2;
    logic                   clk_d;
    logic [4:0]             bitcnt;
    logic [23:0]            shin;
    logic [15:0]            shout;
  } osv_dev_t;

  osv_dev_t r;
  osv_dev_t next_r;

  logic        run_s;
  logic        ov_s;
  logic        fstop_s;
  logic        rise;
  logic [15:0] ceiling;
  logic [15:0] sel;
  logic [15:0] sword;
  logic [15:0] common;
  logic [15:0] rdval;
  logic [24:0] word;
  logic [7:0]  rcmd;
  logic        hit;
  int          ix;
  logic        present;
  logic        fault;
  logic [7:0]  set;
  logic [7:0]  clr;

  // ==========================================================
  // register next state
  always_comb begin
    next_r = r;
    set = 8'h00;
    clr = 8'h00;
    hit = 1'b0;
    ix = 0;
    // pins cross into this domain through two flops each
    next_r.s1 = {LINK.link_clk, LINK.link_frame, LINK.link_mosi, RUN, OV_TRIP, FAULT_STOP};
    next_r.s2 = r.s1;
    next_r.clk_d = r.s2[5];
    rise = r.s2[5] & ~r.clk_d;
    run_s = r.s2[2];
    ov_s = r.s2[1];
    fstop_s = r.s2[0];
    ceiling = r.regs[IX_PWM][PWM_LOW_RANGE] ? CEIL_LOW : CEIL_HIGH; // R11
    case (r.regs[IX_OPR][1:0])
      OPR_MHI: sel = r.regs[IX_MHI]; // R6
      OPR_MLO: sel = r.regs[IX_MLO]; // R8
      default: sel = r.regs[IX_NOM];
    endcase
    common = 16'h0000;
    common[CM_CALC_A] = (r.busy == 7'h00); // R2
    common[CM_CALC_B] = (r.busy == 7'h00); // R2
    sword = {8'h00, r.sv};
    sword[SW_VOUT] = |r.sv;
    sword[SW_CML] = r.cml;
    sword[SW_NOTA] = r.sv[SV_OV_WARN] | r.sv[SV_UV_WARN]; // R4 R10
    // link frame: rw bit, command code, 16 data bits, msb first
    word = {r.shin, r.s2[3]};
    rcmd = word[7:0];
    if (rise && r.bitcnt == 5'd8) begin
      rcmd = word[7:0];
    end else begin
      rcmd = word[23:16];
    end
    for (int i = 0; i < NREG; i++) begin
      if (REG_CMD[i] == rcmd) begin
        hit = 1'b1;
        ix = i;
      end
    end
    case (rcmd)
      CMD_VOUT_MODE: rdval = VOUT_MODE_VAL; // R22
      CMD_CEILING:   rdval = ceiling; // R11
      CMD_COMMON:    rdval = common;
      CMD_STAT_WORD: rdval = sword;
      CMD_STAT_VOUT: rdval = {8'h00, r.sv};
      default:       rdval = hit ? r.regs[ix] : 16'h0000;
    endcase
    if (r.busy != 7'h00) begin
      next_r.busy = r.busy - 7'h01;
    end
    if (!r.s2[4]) begin
      next_r.bitcnt = 5'd0;
    end else if (rise) begin
      next_r.shin = word[23:0];
      next_r.bitcnt = r.bitcnt + 5'd1;
      next_r.shout = {r.shout[14:0], 1'b0};
      if (r.bitcnt == 5'd8) begin
        next_r.shout = rdval;
      end
      if (r.bitcnt == 5'(FRAME_BITS - 1) && !word[24]) begin
        if (rcmd == CMD_STAT_VOUT) begin
          clr = word[7:0];
        end else if (rcmd == CMD_STAT_WORD) begin
          if (word[SW_CML]) next_r.cml = 1'b0;
        end else if (!hit) begin
          next_r.cml = 1'b1; // read-only or unknown code
        end else if (ix <= IX_MLO && (r.st == D_RISE || r.st == D_FALL)) begin
          next_r.regs = r.regs; // R9
        end else if (ix == IX_NOM && word[15:0] > ceiling) begin
          next_r.regs[IX_NOM] = ceiling; // R12
          next_r.cml = 1'b1; // R12
          set[SV_MAX_WARN] = 1'b1; // R12
        end else begin
          next_r.regs[ix] = word[15:0]; // R21
          if (ix == IX_OVF) next_r.busy = CALC_CYC; // R2
        end
      end
    end
    // ==========================================================
    // limit checks on each converter reading, overvoltage fault pin every clock; one reading period bounds the delay
    present = OUT_READING > r.regs[IX_RES]; // R13
    if (READING_STROBE) begin // R5
      if (PEAK_READING > r.regs[IX_OVW]) set[SV_OV_WARN] = 1'b1; // R4
      if (r.st == D_ON && OUT_READING < r.regs[IX_UVW]) set[SV_UV_WARN] = 1'b1; // R10
      if (r.st == D_ON && OUT_READING < r.regs[IX_UVF]) set[SV_UV_FAULT] = 1'b1;
    end
    if (ov_s) set[SV_OV_FAULT] = 1'b1;
    next_r.sv = (r.sv & ~clr) | set; // R23
    fault = ov_s | fstop_s;
    if (ov_s) next_r.ov_hold = 1'b1; // R3
    else if (!run_s) next_r.ov_hold = 1'b0;
    // ==========================================================
    // residual watch outside the drain state
    if (READING_STROBE && r.st != D_DRAIN) begin
      next_r.absent = ~present;
      if (!present) next_r.toff_arm = 1'b0; // R14 R18
    end
    if (r.toff_arm) begin
      next_r.toff = r.toff + 12'h001;
      if (r.toff == TOFF_CYC) begin
        next_r.sv[SV_TOFF] = 1'b1; // R14
        next_r.toff_arm = 1'b0;
      end
    end
    // ==========================================================
    // channel sequencing
    next_r.tmr = r.tmr + 8'h01;
    case (r.st)
      D_OFF: begin
        next_r.target = 16'h0000;
        if (run_s && !r.ov_hold && !fault
            && (r.regs[IX_CFG][CFG_IGNORE] || r.absent)) begin // R15
          next_r.st = D_RISE;
          next_r.tmr = 8'h00;
          next_r.toff_arm = 1'b0;
        end
      end
      D_RISE: begin
        next_r.target = sel;
        if (r.tmr == RAMP_CYC) next_r.st = D_ON;
      end
      D_ON: begin
        // slew toward the selected setpoint one step per clock
        if (r.target < sel) next_r.target = r.target + 16'h0001; // R9
        else if (r.target > sel) next_r.target = r.target - 16'h0001; // R9
        if (!run_s) begin
          next_r.st = D_FALL;
          next_r.tmr = 8'h00;
        end
      end
      D_FALL: begin
        if (r.tmr == RAMP_CYC) begin
          next_r.below = 2'h0;
          next_r.toff = 12'h000;
          next_r.toff_arm = ~r.regs[IX_CFG][CFG_IGNORE];
          next_r.st = r.regs[IX_CFG][CFG_RES_EN] ? D_DRAIN : D_OFF; // R14 R17
        end
      end
      D_DRAIN: begin
        if (READING_STROBE && !present) begin
          next_r.below = r.below + 2'h1; // R16
          next_r.absent = 1'b1;
          next_r.toff_arm = 1'b0; // R18
          if (r.below == 2'h1) next_r.st = D_OFF; // R16
        end
      end
      default: next_r.st = D_OFF;
    endcase
    if (fault && r.st != D_OFF) begin
      next_r.st = D_OFF; // R19
      next_r.toff_arm = 1'b0;
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      r <= '0;
      r.regs <= REG_RST;
      r.absent <= 1'b1;
      r.st <= D_OFF;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // outputs; overvoltage latch forces the low side on
  assign SWITCHING      = (r.st != D_OFF) && !r.ov_hold;
  assign HIGH_SIDE_GATE = SWITCHING && !ov_s; // R3
  assign LOW_SIDE_GATE  = r.ov_hold || ov_s; // R3
  assign RAMPING        = (r.st == D_RISE) || (r.st == D_FALL);
  assign TARGET         = r.target;
  // pulldown-only action keeps the shared alarm quiet
  assign ALARM_N = ~(r.sv[SV_OV_FAULT] && r.regs[IX_OVA][7:0] != 8'h00); // R3
  assign ALERT_N = ~(|(r.sv & ~r.regs[IX_MSK][7:0]) || (r.cml && !r.regs[IX_MSK][8]));
  assign LINK.link_miso = r.shout[15];
endmodule : osv_dev

// >>> osv_host.sv
// link host: takes commands over AXI4-Lite and runs link frames
`timescale 1ns/1ps
module osv_host #(
  parameter int OV_SETTLE = osv_pkg::OV_SETTLE_CYC // cycles after threshold change
) (
  input  wire logic        CLK_SYS, // system clock
  input  wire logic        RESET,   // synchronous, active high
  input  wire logic [7:0]  AWADDR,  // write address
  input  wire logic        AWVALID, // write address valid
  output logic             AWREADY, // write address ready
  input  wire logic [31:0] WDATA,   // write data
  input  wire logic [3:0]  WSTRB,   // byte strobes
  input  wire logic        WVALID,  // write data valid
  output logic             WREADY,  // write data ready
  output logic [1:0]       BRESP,   // write response
  output logic             BVALID,  // write response valid
  input  wire logic        BREADY,  // write response ready
  input  wire logic [7:0]  ARADDR,  // read address
  input  wire logic        ARVALID, // read address valid
  output logic             ARREADY, // read address ready
  output logic [31:0]      RDATA,   // read data
  output logic [1:0]       RRESP,   // read response
  output logic             RVALID,  // read valid
  input  wire logic        RREADY,  // read ready
  osv_link_if.host         LINK     // serial link
);
  import osv_pkg::*;

  typedef struct packed {
    osv_hstate_t st;
    logic        aw_ok;
    logic [7:0]  awa;
    logic        w_ok;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic        bv;
    logic [1:0]  br;
    logic        rv;
    logic [31:0] rd;
    logic [1:0]  rr;
    logic [8:0]  ctrl;
    logic [15:0] wval;
    logic [15:0] rval;
    logic [15:0] nom;
    logic        refused;
    logic        over;
    logic [16:0] settle;
    logic [2:0]  div;
    logic        lclk;
    logic        frame;
    logic [24:0] sh;
    logic [4:0]  bitcnt;
    logic [1:0]  ms;
  } osv_host_t;

  osv_host_t r;
  osv_host_t next_r;
  logic [31:0] m;
  logic [31:0] stat;

  // ==========================================================
  // bus and link next state
  always_comb begin
    next_r = r;
    m = {{8{r.ws[3]}}, {8{r.ws[2]}}, {8{r.ws[1]}}, {8{r.ws[0]}}};
    stat = {28'h0, r.over, r.settle != 17'h0, r.refused, r.st != H_IDLE};
    next_r.ms = {r.ms[0], LINK.link_miso};
    if (r.settle != 17'h0) next_r.settle = r.settle - 17'h1;
    if (AWVALID && AWREADY) begin
      next_r.aw_ok = 1'b1;
      next_r.awa = AWADDR;
    end
    if (WVALID && WREADY) begin
      next_r.w_ok = 1'b1;
      next_r.wd = WDATA;
      next_r.ws = WSTRB;
    end
    if (r.bv && BREADY) next_r.bv = 1'b0;
    if (r.aw_ok && r.w_ok) begin
      next_r.aw_ok = 1'b0;
      next_r.w_ok = 1'b0;
      next_r.bv = 1'b1;
      next_r.br = RESP_OK;
      case (r.awa)
        HA_CTRL: if (r.st == H_IDLE) begin
          // setpoint ordering is checked before anything goes out
          next_r.ctrl = 9'((({23'h0, r.ctrl} & ~m) | (r.wd & m)));
          next_r.refused = 1'b0;
          next_r.st = H_WAIT;
          if (!r.wd[8] && r.wd[7:0] == CMD_MARGIN_HI
              && (r.wval <= r.nom || r.wval > MHI_GUAR_MAX)) begin // R6
            next_r.refused = 1'b1;
            next_r.st = H_IDLE;
          end
          if (!r.wd[8] && r.wd[7:0] == CMD_MARGIN_LO && r.wval >= r.nom) begin // R8
            next_r.refused = 1'b1;
            next_r.st = H_IDLE;
          end
          if (!r.wd[8] && r.wd[7:0] == CMD_NOMINAL && r.wval > NOM_GUAR_MAX) begin
            next_r.over = 1'b1; // R7
          end
        end
        HA_WDATA: next_r.wval = 16'(({16'h0, r.wval} & ~m) | (r.wd & m));
        HA_STAT: if (r.wd[3]) next_r.over = 1'b0;
        default: next_r.br = RESP_ERR;
      endcase
    end
    if (r.rv && RREADY) next_r.rv = 1'b0;
    if (ARVALID && ARREADY) begin
      next_r.rv = 1'b1;
      next_r.rr = RESP_OK;
      case (ARADDR)
        HA_CTRL:  next_r.rd = {23'h0, r.ctrl};
        HA_WDATA: next_r.rd = {16'h0, r.wval};
        HA_RDATA: next_r.rd = {16'h0, r.rval};
        HA_STAT:  next_r.rd = stat;
        default: begin
          next_r.rd = 32'h0;
          next_r.rr = RESP_ERR;
        end
      endcase
    end
    // ==========================================================
    // link frames; the link clock is a divided system clock
    case (r.st)
      H_IDLE: next_r.frame = 1'b0;
      H_WAIT: begin
        // a nominal write waits out the threshold settle time
        if (!(r.ctrl[7:0] == CMD_NOMINAL && r.settle != 17'h0)) begin // R1
          next_r.st = H_SHIFT;
          next_r.frame = 1'b1;
          next_r.sh = {r.ctrl[8], r.ctrl[7:0], r.wval};
          next_r.bitcnt = 5'd0;
          next_r.div = 3'd0;
        end
      end
      H_SHIFT: begin
        next_r.div = r.div + 3'd1;
        if (r.div == 3'(LINK_HALF - 1)) begin
          next_r.div = 3'd0;
          next_r.lclk = ~r.lclk;
          if (!r.lclk) begin
            next_r.bitcnt = r.bitcnt + 5'd1;
            if (r.ctrl[8] && r.bitcnt >= 5'd9) next_r.rval = {r.rval[14:0], r.ms[1]};
          end else if (r.bitcnt == 5'(FRAME_BITS)) begin
            next_r.st = H_IDLE;
            next_r.frame = 1'b0;
            if (!r.ctrl[8] && r.ctrl[7:0] == REG_CMD[IX_OVF]) begin
              next_r.settle = 17'(OV_SETTLE); // R1
            end
            if (!r.ctrl[8] && r.ctrl[7:0] == CMD_NOMINAL) next_r.nom = r.wval;
          end else begin
            next_r.sh = {r.sh[23:0], 1'b0};
          end
        end
      end
      default: next_r.st = H_IDLE;
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      r <= '0;
      r.nom <= REG_RST[IX_NOM];
      r.st <= H_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign AWREADY = !r.aw_ok && !r.bv;
  assign WREADY  = !r.w_ok && !r.bv;
  assign BVALID  = r.bv;
  assign BRESP   = r.br;
  assign ARREADY = !r.rv;
  assign RVALID  = r.rv;
  assign RDATA   = r.rd;
  assign RRESP   = r.rr;
  assign LINK.link_clk   = r.lclk;
  assign LINK.link_frame = r.frame;
  assign LINK.link_mosi  = r.sh[24];
endmodule : osv_host

// >>> osv_link_if.sv
// serial link between the supervisor and its host
`timescale 1ns/1ps
interface osv_link_if;
  logic link_clk;   // made by the host
  logic link_frame; // high for a whole frame
  logic link_mosi;  // host to device, msb first
  logic link_miso;  // device to host, read data
  modport host (output link_clk, output link_frame, output link_mosi, input link_miso);
  modport dev (input link_clk, input link_frame, input link_mosi, output link_miso);
endinterface : osv_link_if

// >>> osv_pkg.sv
// shared constants and types for the output limit supervisor and its host
//
// Notes on behaviour
// (R1) host waits 10ms after overvoltage fault threshold change
// (R2) bits 5,6 low while threshold calculation runs
// (R3) pulldown-only action: no alarm, gates pull down
// (R4) peak above overvoltage warning sets warning, alert
// (R5) warning flagged within one converter reading, 120ms
// (R6) upper margin above nominal, guaranteed to 13.8V
// (R7) nominal above 13.2V is not guaranteed
// (R8) lower margin below nominal, selected by operation
// (R9) setpoint writes ignored while ramping; slew when steady
// (R10) reading below undervoltage warning sets warning, alert
// (R11) ceiling 14.0V high range, 7.0V low range
// (R12) nominal above ceiling: clamp, comms fault, bit 3
// (R13) residual present when reading exceeds residual threshold
// (R14) residual disabled: no shutdown delay, gates off-time warning
// (R15) no turn-on while residual present unless ignored
// (R16) residual enabled: two readings below before shutdown
// (R17) residual checks start only after ramp-down ends
// (R18) one reading below marks residual absent
// (R19) fault shutdown bypasses residual gating, stops at once
// (R20) suggest residual threshold 12.5%, ignore flag set; reset threshold is 10% of reset nominal
// (R21) gain is linear 5/11 bits, setpoints 16-bit unsigned
// (R22) format byte: 3-bit mode, 5-bit exponent
// (R23) status bits stay set until host clears them
package osv_pkg;
  // ==========================================================
  // command codes
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_VOUT_MODE = 8'h20;
  localparam logic [7:0] CMD_NOMINAL   = 8'h21;
  localparam logic [7:0] CMD_MARGIN_HI = 8'h25;
  localparam logic [7:0] CMD_MARGIN_LO = 8'h26;
  localparam logic [7:0] CMD_STAT_WORD = 8'h79;
  localparam logic [7:0] CMD_STAT_VOUT = 8'h7A;
  localparam logic [7:0] CMD_CEILING   = 8'hA5;
  localparam logic [7:0] CMD_COMMON    = 8'hEF;
  // ==========================================================
  // writable register file: index, code, reset value
  localparam int NREG = 17;
  localparam int IX_NOM = 0;
  localparam int IX_MHI = 1;
  localparam int IX_MLO = 2;
  localparam int IX_OVF = 3;
  localparam int IX_OVW = 4;
  localparam int IX_UVW = 5;
  localparam int IX_UVF = 6;
  localparam int IX_RES = 7;
  localparam int IX_OPR = 12;
  localparam int IX_OVA = 13;
  localparam int IX_PWM = 14;
  localparam int IX_CFG = 15;
  localparam int IX_MSK = 16;
  localparam logic [NREG-1:0][7:0] REG_CMD = {
    8'hD0, 8'hD2, 8'hD4, 8'h41, CMD_OPERATION, 8'hF6, 8'h4A, 8'h46, 8'h38,
    8'hDA, 8'h44, 8'h43, 8'h42, 8'h40, CMD_MARGIN_LO, CMD_MARGIN_HI, CMD_NOMINAL};
  localparam logic [NREG-1:0][15:0] REG_RST = {
    16'h0000, 16'h0001, 16'h0000, 16'h0080, 16'h0000, 16'h0F3C, 16'hDA80,
    16'hDBB8, 16'hBB9A, 16'h019A, 16'h0E66, 16'h0ECD, 16'h1133, 16'h119A,
    16'h0F33, 16'h10CD, 16'h1000};
  // ==========================================================
  // fields and fixed values
  localparam logic [15:0] VOUT_MODE_VAL = 16'h0014; // mode 000, exponent -12
  localparam logic [15:0] CEIL_HIGH     = 16'hE000; // 14.0V
  localparam logic [15:0] CEIL_LOW      = 16'h7000; // 7.0V
  localparam logic [15:0] NOM_GUAR_MAX  = 16'hD333; // 13.2V
  localparam logic [15:0] MHI_GUAR_MAX  = 16'hDCCC; // 13.8V
  localparam int PWM_LOW_RANGE = 1;
  localparam int CFG_IGNORE    = 0;
  localparam int CFG_RES_EN    = 5;
  localparam int OPR_ON        = 7;
  localparam logic [1:0] OPR_MHI = 2'h1;
  localparam logic [1:0] OPR_MLO = 2'h2;
  localparam int SV_OV_FAULT = 7;
  localparam int SV_OV_WARN  = 6;
  localparam int SV_UV_WARN  = 5;
  localparam int SV_UV_FAULT = 4;
  localparam int SV_MAX_WARN = 3;
  localparam int SV_TOFF     = 2;
  localparam int SW_VOUT     = 15;
  localparam int SW_CML      = 1;
  localparam int SW_NOTA     = 0;
  localparam int CM_CALC_A   = 5;
  localparam int CM_CALC_B   = 6;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS  = 100;
  localparam int CLK_HZ         = 10_000_000;
  localparam int LINK_PERIOD_NS = 800;
  localparam int LINK_HALF      = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int OV_SETTLE_MS   = 10;
  localparam int OV_SETTLE_CYC  = CLK_HZ / 1000 * OV_SETTLE_MS;
  localparam logic [6:0] CALC_CYC  = 7'h40;
  localparam logic [7:0] RAMP_CYC  = 8'h14;
  localparam logic [11:0] TOFF_CYC = 12'h7D0;
  localparam int FRAME_BITS = 25; // rw, code, 16 data bits
  // ==========================================================
  // host register map (byte addresses)
  localparam logic [7:0] HA_CTRL  = 8'h00;
  localparam logic [7:0] HA_WDATA = 8'h04;
  localparam logic [7:0] HA_RDATA = 8'h08;
  localparam logic [7:0] HA_STAT  = 8'h0C;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum logic [2:0] {D_OFF, D_RISE, D_ON, D_FALL, D_DRAIN} osv_dstate_t;
  typedef enum logic [1:0] {H_IDLE, H_WAIT, H_SHIFT} osv_hstate_t;
endpackage : osv_pkg

// >>> osv_props.sv
// link checker for the supervisor link
`timescale 1ns/1ps
// ==========
// checker
module osv_props (
  input wire logic CLK_SYS,    // system clock
  input wire logic RESET,      // sync reset
  input wire logic link_clk,   // link clock
  input wire logic link_frame, // frame
  input wire logic link_mosi,  // host data
  input wire logic link_miso   // device data
);
  logic [7:0] fcnt; // cycles in frame
  logic [4:0] rcnt; // clock rises in frame
  logic       pclk; // last link clock
  // counters restart on every idle cycle, so no reset is needed
  always_ff @(posedge CLK_SYS) begin
    pclk <= link_clk;
    fcnt <= link_frame ? fcnt + 8'h01 : 8'h00;
    rcnt <= link_frame ? rcnt + 5'(link_clk && !pclk) : 5'h00;
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  AST_IDLE_CLK: assert property (!link_frame |-> !link_clk)
    else $error("link clock moved outside a frame");
  AST_FIRST_HALF: assert property ($rose(link_frame) |-> !link_clk [*4] ##1 link_clk)
    else $error("first link clock rise late or early");
  AST_HIGH_HALF: assert property ($rose(link_clk) |-> link_clk [*4] ##1 !link_clk)
    else $error("link clock high phase wrong");
  AST_LOW_HALF: assert property ($fell(link_clk) && link_frame |-> !link_clk [*4] ##1 link_clk)
    else $error("link clock low phase wrong");
  AST_MOSI_HOLD: assert property (link_clk |-> $stable(link_mosi))
    else $error("host data moved while link clock high");
  AST_FRAME_LEN: assert property ($fell(link_frame) |-> fcnt == 8'hC8)
    else $error("frame length wrong");
  AST_RISE_COUNT: assert property ($fell(link_frame) |-> rcnt == 5'h19)
    else $error("frame bit count wrong");
  AST_GAP: assert property ($fell(link_frame) |-> ##1 !link_frame)
    else $error("frames back to back");
  AST_RESET_IDLE: assert property (disable iff (1'b0) $past(RESET) |-> !link_frame && !link_clk)
    else $error("link not idle after reset");
  AST_MISO_IDLE: assert property (!link_frame |-> !link_miso)
    else $error("device data moved outside a frame");
  cover property ($fell(link_frame));
  cover property ($rose(link_frame) && link_mosi);
  cover property ($rose(link_frame) && !link_mosi);
endmodule : osv_props

// >>> testbench.sv
// self-checking bench: host and device joined by the link
`timescale 1ns/1ps
// ==========
// bench
module testbench;
  import osv_pkg::*;
  logic        clk, rst, awv, wv, bry, arv, rry, run, ovt, strb;
  logic [7:0]  awa, ara;
  logic [31:0] wd, v;
  logic [15:0] peak, outr;
  logic [1:0]  r;
  wire logic   awr, wr, bv, arr, rv, hsg, lsg, alm_n, alt_n, sw, rmp;
  wire logic [1:0]  br, rr;
  wire logic [31:0] rd;
  wire logic [15:0] tgt;
  int num_errors = 0;
  int num_checks = 0;
  osv_link_if lnk ();
  osv_host #(.OV_SETTLE(50)) u_osv_host (.CLK_SYS(clk), .RESET(rst), .AWADDR(awa),
    .AWVALID(awv), .AWREADY(awr), .WDATA(wd), .WSTRB(4'hF), .WVALID(wv), .WREADY(wr),
    .BRESP(br), .BVALID(bv), .BREADY(bry), .ARADDR(ara), .ARVALID(arv), .ARREADY(arr),
    .RDATA(rd), .RRESP(rr), .RVALID(rv), .RREADY(rry), .LINK(lnk));
  osv_dev u_osv_dev (.CLK_SYS(clk), .RESET(rst), .LINK(lnk), .RUN(run), .OV_TRIP(ovt),
    .FAULT_STOP(1'b0), .READING_STROBE(strb), .OUT_READING(outr), .PEAK_READING(peak),
    .HIGH_SIDE_GATE(hsg), .LOW_SIDE_GATE(lsg), .SWITCHING(sw), .RAMPING(rmp), .TARGET(tgt),
    .ALARM_N(alm_n), .ALERT_N(alt_n));
  osv_props u_osv_props (.CLK_SYS(clk), .RESET(rst), .link_clk(lnk.link_clk),
    .link_frame(lnk.link_frame), .link_mosi(lnk.link_mosi), .link_miso(lnk.link_miso));
  // clock and hang limit; a whole run needs far fewer cycles than this
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    final_report;
  end
  task final_report;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // bus master: each channel held until its own ready
  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {awa, wd, awv, wv, bry} <= {a, d, 3'b111};
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
    end while (!(bv === 1'b1));
    bry <= 1'b0;
  endtask : axi_wr
  task axi_rd(input logic [7:0] a);
    @(posedge clk);
    {ara, arv, rry} <= {a, 2'b11};
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
    end while (!(rv === 1'b1));
    {v, r} = {rd, rr};
    rry <= 1'b0;
  endtask : axi_rd
  // link commands run through the host, then wait for its busy flag to drop
  task dwr(input logic [7:0] c, input logic [15:0] d);
    axi_wr(HA_WDATA, {16'h0000, d});
    axi_wr(HA_CTRL, {24'h000000, c});
    do axi_rd(HA_STAT); while (v[0] !== 1'b0);
  endtask : dwr
  task drd(input logic [7:0] c);
    axi_wr(HA_CTRL, {23'h000000, 1'b1, c});
    do axi_rd(HA_STAT); while (v[0] !== 1'b0);
    axi_rd(HA_RDATA);
  endtask : drd
  // ==========
  // scenarios
  task t_fixed;
    drd(CMD_CEILING);
    chk(v, {16'h0000, CEIL_HIGH});
    drd(CMD_VOUT_MODE);
    chk(v, {16'h0000, VOUT_MODE_VAL});
    axi_rd(8'h10);
    chk(v, 32'h0);
    chk(r, RESP_ERR);
    $display("t_fixed done");
  endtask : t_fixed
  // one reading above the limit, then one below: the flag must stay
  task t_warn;
    chk(alt_n, 1'b1);
    @(posedge clk);
    {strb, peak} <= {1'b1, 16'h1200};
    @(posedge clk);
    peak <= 16'h0000;
    @(posedge clk);
    strb <= 1'b0;
    repeat (5) @(posedge clk);
    chk(alt_n, 1'b0);
    drd(CMD_STAT_VOUT);
    chk(v[SV_OV_WARN], 1'b1);
    drd(CMD_STAT_WORD);
    chk({v[SW_VOUT], v[SW_NOTA]}, 2'b11);
    dwr(CMD_STAT_VOUT, 16'h0040);
    drd(CMD_STAT_VOUT);
    chk(v[SV_OV_WARN], 1'b0);
    $display("t_warn done");
  endtask : t_warn
  task t_clamp;
    dwr(REG_CMD[IX_PWM], 16'h0002);
    drd(CMD_CEILING);
    chk(v, {16'h0000, CEIL_LOW});
    dwr(CMD_NOMINAL, 16'h8000);
    drd(CMD_NOMINAL);
    chk(v, {16'h0000, CEIL_LOW});
    drd(CMD_STAT_VOUT);
    chk(v[SV_MAX_WARN], 1'b1);
    drd(CMD_STAT_WORD);
    chk(v[SW_CML], 1'b1);
    $display("t_clamp done");
  endtask : t_clamp
  // run past the ramp, then trip with the pulldown-only action
  task t_pulldown;
    dwr(REG_CMD[IX_OVA], 16'h0000);
    run <= 1'b1;
    dwr(CMD_OPERATION, 16'h0080);
    repeat (40) @(posedge clk);
    chk(hsg, 1'b1);
    chk(tgt, {16'h0000, CEIL_LOW});
    ovt <= 1'b1;
    repeat (5) @(posedge clk);
    chk({hsg, lsg, alm_n}, 3'b011);
    {run, ovt} <= 2'b00;
    $display("t_pulldown done");
  endtask : t_pulldown
  task rdg(input logic [15:0] o);
    @(posedge clk);
    {strb, outr} <= {1'b1, o};
    @(posedge clk);
    strb <= 1'b0;
  endtask : rdg
  task t_limits;
    dwr(CMD_MARGIN_HI, 16'h0100);
    chk(v[1], 1'b1);
    dwr(CMD_MARGIN_LO, 16'hF000);
    chk(v[1], 1'b1);
    dwr(REG_CMD[IX_OVF], 16'h1200);
    axi_rd(HA_STAT);
    chk(v[2], 1'b1);
    dwr(CMD_NOMINAL, 16'hD400);
    chk(v[3:2], 2'b10);
    $display("t_limits done");
  endtask : t_limits
  task t_drain;
    dwr(REG_CMD[IX_RES], 16'h0E00);
    dwr(REG_CMD[IX_CFG], 16'h0020);
    run <= 1'b1;
    repeat (30) @(posedge clk);
    chk(sw, 1'b0);
    rdg(16'h0100);
    repeat (40) @(posedge clk);
    chk(sw, 1'b1);
    run <= 1'b0;
    repeat (10) @(posedge clk);
    chk(rmp, 1'b1);
    rdg(16'h0100);
    repeat (30) @(posedge clk);
    rdg(16'h0100);
    repeat (3) @(posedge clk);
    chk(sw, 1'b1);
    rdg(16'h0100);
    repeat (3) @(posedge clk);
    chk(sw, 1'b0);
    $display("t_drain done");
  endtask : t_drain
  // main sequence
  initial begin
    {rst, awv, wv, bry, arv, rry, run, ovt, strb} = 9'h100;
    {awa, ara, wd, peak, outr} = 80'h1000;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_fixed;
    t_warn;
    t_clamp;
    t_pulldown;
    t_limits;
    t_drain;
    final_report;
  end
endmodule : testbench
